// File: logic/lifetime_timer_pkg.sv
package lifetime_timer_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_LOAD       = 32'hFFFF_0300;
  localparam logic [31:0] ADDR_COUNT_LOW  = 32'hFFFF_0304;
  localparam logic [31:0] ADDR_COUNT_HIGH = 32'hFFFF_0308;
  localparam logic [31:0] ADDR_CONTROL    = 32'hFFFF_030C;
  localparam logic [31:0] ADDR_IRQ_CLEAR  = 32'hFFFF_0310;
  localparam logic [31:0] ADDR_CAPTURE    = 32'hFFFF_0314;

  // reset values
  localparam logic [15:0] LOAD_RESET    = 16'h0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [47:0] COUNT_RESET   = 48'h0000_0000_0000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

  // control field positions
  localparam int CTL_PRESC_LSB    = 0;
  localparam int CTL_WIDE_BIT     = 4;
  localparam int CTL_PERIODIC_BIT = 6;
  localparam int CTL_ENABLE_BIT   = 7;
  localparam int CTL_UP_BIT       = 8;
  localparam int CTL_CLKSEL_LSB   = 9;
  localparam int CTL_EVSEL_LSB    = 12;
  localparam int CTL_CAPEN_BIT    = 17;

  // clock source codes
  localparam logic [1:0] CLK_CORE  = 2'h0;
  localparam logic [1:0] CLK_LPOSC = 2'h1;
  localparam logic [1:0] CLK_XTAL  = 2'h2;
  localparam logic [1:0] CLK_PREC  = 2'h3;

  // prescale codes and terminal counts of the divider
  localparam logic [3:0]  PRESC_DIV16    = 4'h4;
  localparam logic [3:0]  PRESC_DIV256   = 4'h8;
  localparam logic [3:0]  PRESC_DIV32768 = 4'hF;
  localparam logic [14:0] PRESC_TC1      = 15'h0000;
  localparam logic [14:0] PRESC_TC16     = 15'h000F;
  localparam logic [14:0] PRESC_TC256    = 15'h00FF;
  localparam logic [14:0] PRESC_TC32768  = 15'h7FFF;

  // narrow counter bounds and counter increments
  localparam logic [15:0] NARROW_ZERO = 16'h0000;
  localparam logic [15:0] NARROW_FULL = 16'hFFFF;
  localparam logic [47:0] WIDE_ONE    = 48'h0000_0000_0001;
  localparam logic [15:0] NARROW_ONE  = 16'h0001;
  localparam logic [31:0] HIGH_ZERO   = 32'h0000_0000;

  // event sources
  localparam int         NUM_EVENTS = 18;
  localparam logic [4:0] EVENT_LAST = 5'h11;

  typedef enum logic [0:0] {
    PH_SETUP = 1'b0,
    PH_DONE  = 1'b1
  } bus_phase_t;

endpackage

// File: logic/presc_divider.sv
`timescale 1ns/10ps
`default_nettype none
module presc_divider
  import lifetime_timer_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // source and control
  input  wire logic       src_tick,
  input  wire logic       run,
  input  wire logic [3:0] code,
  // divided tick
  output logic            tick
);

  typedef struct packed {
    logic [14:0] cnt;
  } presc_state_t;

  presc_state_t s_reg;
  presc_state_t s_next;
  logic [14:0]  tc;

  // unlisted codes fall back to divide by one
  always_comb
  begin
    case (code)
      PRESC_DIV16:    tc = PRESC_TC16;
      PRESC_DIV256:   tc = PRESC_TC256;
      PRESC_DIV32768: tc = PRESC_TC32768;
      default:        tc = PRESC_TC1;
    endcase
  end

  always_comb
  begin
    s_next = s_reg;
    tick = 1'b0;
    if (!run)
    begin
      s_next.cnt = PRESC_TC1;
    end
    else if (src_tick)
    begin
      // a lowered ratio while mid-count ends the period at once
      if (s_reg.cnt >= tc)
      begin
        tick = 1'b1;
        s_next.cnt = PRESC_TC1;
      end
      else
      begin
        s_next.cnt = s_reg.cnt + 15'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

endmodule
`default_nettype wire

// File: logic/lifetime_timer.sv
`timescale 1ns/10ps
`default_nettype none
module lifetime_timer
  import lifetime_timer_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator ticks, one pclk cycle each
  input  wire logic        lp_osc_tick,
  input  wire logic        xtal_tick,
  input  wire logic        prec_osc_tick,
  // interrupt sources of other blocks, bit 0 unused
  input  wire logic [17:0] event_sources,
  // timer interrupt level
  output logic             timer_irq
);

  import lifetime_timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    bus_phase_t  phase;
    logic        ready;
    logic        err;
    logic [31:0] rdata;
    logic [31:0] ctl_mmr;
    logic [15:0] ld_mmr;
    logic [31:0] ctl_s1;
    logic [31:0] ctl_s2;
    logic [15:0] ld_s1;
    logic [15:0] ld_s2;
    logic        en_prev;
    logic [47:0] count;
    logic        irq;
    logic [15:0] capture;
    logic        ev_prev;
  } timer_state_t;

  timer_state_t s_reg;
  timer_state_t s_next;

  logic                  src_tick;
  logic                  cnt_tick;
  logic                  run;
  logic                  start;
  logic                  wide;
  logic                  count_up;
  logic                  periodic;
  logic                  narrow_event;
  logic                  ev_sel;
  logic                  wr_done;
  logic                  hit;
  logic [31:0]           rd_val;
  logic [NUM_EVENTS-1:0] ev_vec;
  logic [4:0]            ev_idx;
  logic [15:0]           low_next;

  ////////////////////////////////////////////////////////////////////////////
  // source selection and prescaler

  always_comb
  begin
    case (s_reg.ctl_mmr[CTL_CLKSEL_LSB +: 2])
      CLK_CORE:  src_tick = 1'b1;
      CLK_LPOSC: src_tick = lp_osc_tick;
      CLK_XTAL:  src_tick = xtal_tick;
      CLK_PREC:  src_tick = prec_osc_tick;
      default:   src_tick = 1'b0;
    endcase
  end

  assign run      = s_reg.ctl_s2[CTL_ENABLE_BIT];
  assign wide     = s_reg.ctl_s2[CTL_WIDE_BIT];
  assign count_up = s_reg.ctl_s2[CTL_UP_BIT];
  assign periodic = s_reg.ctl_s2[CTL_PERIODIC_BIT];
  assign start    = run && !s_reg.en_prev;

  presc_divider u_presc (
    .pclk     (pclk),
    .presetn  (presetn),
    .src_tick (src_tick),
    .run      (run),
    .code     (s_reg.ctl_s2[CTL_PRESC_LSB +: 4]),
    .tick     (cnt_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event source selection

  // index 0 is this timer's own interrupt
  generate
    for (genvar i = 0; i < NUM_EVENTS; i++)
    begin : g_ev
      if (i == 0)
        assign ev_vec[i] = s_reg.irq;
      else
        assign ev_vec[i] = event_sources[i];
    end
  endgenerate

  // source index, out of range picks nothing
  assign ev_idx = s_reg.ctl_s2[CTL_EVSEL_LSB +: 5];
  assign ev_sel = (ev_idx <= EVENT_LAST) ? ev_vec[ev_idx] : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // register read decode

  always_comb
  begin
    hit = 1'b1;
    rd_val = DATA_ZERO;
    case (paddr)
      ADDR_LOAD:       rd_val = {16'h0000, s_reg.ld_mmr};
      ADDR_COUNT_LOW:  rd_val = {16'h0000, s_reg.count[15:0]};
      ADDR_COUNT_HIGH: rd_val = s_reg.count[47:16];
      // reserved bits read back as written
      ADDR_CONTROL:    rd_val = s_reg.ctl_mmr;
      ADDR_IRQ_CLEAR:  rd_val = DATA_ZERO;
      ADDR_CAPTURE:    rd_val = {16'h0000, s_reg.capture};
      default:         hit = 1'b0;
    endcase
  end

  assign wr_done = psel && penable && s_reg.ready && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_next = s_reg;
    narrow_event = 1'b0;
    low_next = s_reg.count[15:0];

    // bus phase: one wait-free access cycle after each setup
    case (s_reg.phase)
      PH_SETUP:
      begin
        if (psel && !penable)
        begin
          s_next.phase = PH_DONE;
          s_next.ready = 1'b1;
          s_next.err   = !hit;
          s_next.rdata = (hit && !pwrite) ? rd_val : DATA_ZERO;
        end
      end
      PH_DONE:
      begin
        s_next.phase = PH_SETUP;
        s_next.ready = 1'b0;
        s_next.err   = 1'b0;
        s_next.rdata = DATA_ZERO;
      end
      default:
      begin
        s_next.phase = PH_SETUP;
        s_next.ready = 1'b0;
      end
    endcase

    // register writes take effect at the completing edge
    if (wr_done && paddr == ADDR_CONTROL)
      s_next.ctl_mmr = pwdata;
    if (wr_done && paddr == ADDR_LOAD)
      s_next.ld_mmr = pwdata[15:0];

    // two stage transfer, clocked by the selected source tick
    if (src_tick)
    begin
      s_next.ctl_s1 = s_reg.ctl_mmr;
      s_next.ctl_s2 = s_reg.ctl_s1;
      s_next.ld_s1  = s_reg.ld_mmr;
      s_next.ld_s2  = s_reg.ld_s1;
    end

    s_next.en_prev = run;

    // counter
    if (start)
    begin
      // narrow mode starts from the load value
      if (wide)
        s_next.count = COUNT_RESET;
      else
        s_next.count = {HIGH_ZERO, s_reg.ld_s2};
    end
    else if (run && cnt_tick)
    begin
      if (wide)
      begin
        s_next.count = s_reg.count + WIDE_ONE;
      end
      else
      begin
        if (count_up)
        begin
          if (s_reg.count[15:0] == NARROW_FULL)
            low_next = periodic ? s_reg.ld_s2 : NARROW_ZERO;
          else
            low_next = s_reg.count[15:0] + NARROW_ONE;
          narrow_event = (low_next == NARROW_FULL);
        end
        else
        begin
          if (s_reg.count[15:0] == NARROW_ZERO)
            low_next = periodic ? s_reg.ld_s2 : NARROW_FULL;
          else
            low_next = s_reg.count[15:0] - NARROW_ONE;
          narrow_event = (low_next == NARROW_ZERO);
        end
        s_next.count = {HIGH_ZERO, low_next};
      end
    end

    // clear by any write, narrow only; a same-cycle event wins
    if (wr_done && paddr == ADDR_IRQ_CLEAR && !wide)
      s_next.irq = 1'b0;
    if (narrow_event)
      s_next.irq = 1'b1;

    // capture on each rising edge of the selected event in narrow mode, counter keeps running
    s_next.ev_prev = ev_sel;
    if (ev_sel && !s_reg.ev_prev && s_reg.ctl_s2[CTL_CAPEN_BIT] && !wide)
      s_next.capture = s_reg.count[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg.phase   <= PH_SETUP;
      s_reg.ready   <= 1'b0;
      s_reg.err     <= 1'b0;
      s_reg.rdata   <= DATA_ZERO;
      s_reg.ctl_mmr <= CONTROL_RESET;
      s_reg.ld_mmr  <= LOAD_RESET;
      s_reg.ctl_s1  <= CONTROL_RESET;
      s_reg.ctl_s2  <= CONTROL_RESET;
      s_reg.ld_s1   <= LOAD_RESET;
      s_reg.ld_s2   <= LOAD_RESET;
      s_reg.en_prev <= 1'b0;
      s_reg.count   <= COUNT_RESET;
      s_reg.irq     <= 1'b0;
      s_reg.capture <= CAPTURE_RESET;
      s_reg.ev_prev <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign prdata    = s_reg.rdata;
  assign pready    = s_reg.ready;
  assign pslverr   = s_reg.err;
  assign timer_irq = s_reg.irq;

endmodule
`default_nettype wire

// File: tb/lifetime_timer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module lifetime_timer_chk
  import lifetime_timer_pkg::*;
(
  // clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // sources and interrupt
  input wire logic        lp_osc_tick,
  input wire logic        xtal_tick,
  input wire logic        prec_osc_tick,
  input wire logic [17:0] event_sources,
  input wire logic        timer_irq
);
  logic [31:0] ctl_q;
  logic [3:0]  since;
  logic        clr_wr;
  logic        quiet;
  assign clr_wr = psel && penable && pready && pwrite && paddr == ADDR_IRQ_CLEAR;
  // settled: both sync stages long past the last control write
  assign quiet = since == 4'hF;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_q <= CONTROL_RESET;
      since <= 4'hF;
    end
    else if (psel && penable && pready && pwrite && paddr == ADDR_CONTROL)
    begin
      ctl_q <= pwdata;
      since <= 4'h0;
    end
    else if (!quiet)
      since <= since + 4'h1;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_s(logic [31:0] a);
    setup_s ##0 (!pwrite && paddr == a);
  endsequence
  chk_ready_pulse: assert property (setup_s |=> pready ##1 !pready)
    else $error("pready is not a one-cycle pulse");
  chk_unmapped_err: assert property (setup_s ##0 paddr == 32'hFFFF_0318 |=> pslverr)
    else $error("unmapped access without error");
  chk_clear_reads: assert property (rd_s(ADDR_IRQ_CLEAR) |=> prdata == DATA_ZERO)
    else $error("clear register read not zero");
  chk_ctl_readback: assert property (rd_s(ADDR_CONTROL) |=> prdata == ctl_q)
    else $error("control readback differs");
  chk_high_narrow: assert property (rd_s(ADDR_COUNT_HIGH) ##0 quiet
    && !ctl_q[CTL_WIDE_BIT] |=> prdata == DATA_ZERO)
    else $error("high count nonzero in narrow mode");
  chk_irq_hold: assert property (timer_irq && !clr_wr |=> timer_irq)
    else $error("interrupt dropped without clear");
  chk_irq_clear: assert property (clr_wr && quiet && ctl_q[7:4] == 4'h0 |=> !timer_irq)
    else $error("clear write did not clear");
  chk_clear_wide: assert property (clr_wr && quiet && ctl_q[CTL_WIDE_BIT] && timer_irq
    |=> timer_irq)
    else $error("clear acted in wide mode");
endmodule
bind lifetime_timer lifetime_timer_chk u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .lp_osc_tick, .xtal_tick, .prec_osc_tick, .event_sources, .timer_irq
);
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lifetime_timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_irq, er;
  logic        lp_osc_tick = 0, xtal_tick = 0, prec_osc_tick = 0;
  logic [31:0] paddr, pwdata, prdata, rd, c;
  logic [17:0] event_sources;
  int          n_fail = 0, samples_checked = 0, cyc = 0, seed = 9169, i, k;
  logic [5:0]  tbl [8] = '{6'h00, 6'h04, 6'h08, 6'h0F, 6'h05, 6'h10, 6'h20, 6'h34};
  lifetime_timer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .lp_osc_tick, .xtal_tick, .prec_osc_tick,
    .event_sources, .timer_irq);
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // oscillators tick every third cycle, each on its own phase
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    lp_osc_tick <= cyc % 3 == 0;
    xtal_tick <= cyc % 3 == 1;
    prec_osc_tick <= cyc % 3 == 2;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim;
    end
  end
  ////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    samples_checked++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h want %h..%h", $time, g, lo, hi);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdw(input logic [31:0] a);
    apb(1'b0, a, 0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wirq;
    for (k = 0; k < 400 && timer_irq !== 1'b1; k++) @(posedge pclk);
  endtask
  function automatic int exp_count(input logic [5:0] e, input int w);
    int d;
    d = e[3:0] == 4'h4 ? 16 : e[3:0] == 4'h8 ? 256 : e[3:0] == 4'hF ? 32768 : 1;
    return w / (e[5:4] == 2'h0 ? d : 3 * d);
  endfunction
  ////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = '0;
    pwdata = '0;
    event_sources = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      rdw(ADDR_LOAD + 4 * i);
      chk(rd, 0, 0);
    end
    apb(1'b1, ADDR_COUNT_LOW, $random(seed));
    rdw(ADDR_COUNT_LOW);
    chk(rd, 0, 0);
    rdw(32'hFFFF_0318);
    chk({31'h0, er}, 1, 1);
    $display("done reset");
    for (i = 0; i < 6; i++)
    begin
      c = $random(seed) & 32'hFFFF_FF7F;
      apb(1'b1, ADDR_CONTROL, c);
      rdw(ADDR_CONTROL);
      chk(rd, c, c);
      apb(1'b1, ADDR_LOAD, c);
      rdw(ADDR_LOAD);
      chk(rd, {16'h0, c[15:0]}, {16'h0, c[15:0]});
    end
    apb(1'b1, ADDR_CONTROL, 0);
    apb(1'b1, ADDR_LOAD, 0);
    $display("done readback");
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, ADDR_CONTROL, {21'h0, tbl[i][5:4], 5'h18, tbl[i][3:0]});
      wt(600);
      rdw(ADDR_COUNT_LOW);
      k = exp_count(tbl[i], 600);
      chk(rd, k > 6 ? k - 6 : 0, k + 1);
      apb(1'b1, ADDR_CONTROL, 0);
      wt(12);
    end
    $display("done prescale");
    apb(1'b1, ADDR_LOAD, 5);
    apb(1'b1, ADDR_CONTROL, 32'hC0);
    wirq;
    chk({31'h0, timer_irq}, 1, 1);
    for (i = 0; i < 3; i++)
    begin
      wt($random(seed) & 15);
      rdw(ADDR_COUNT_LOW);
      chk(rd, 0, 5);
    end
    apb(1'b1, ADDR_CONTROL, 32'h80);
    wt(40);
    rdw(ADDR_COUNT_LOW);
    chk(rd, 32'hFF00, 32'hFFFF);
    apb(1'b1, ADDR_CONTROL, 32'h10);
    wt(20);
    apb(1'b1, ADDR_IRQ_CLEAR, $random(seed));
    // let the clear edge settle before looking
    wt(1);
    chk({31'h0, timer_irq}, 1, 1);
    apb(1'b1, ADDR_CONTROL, 0);
    wt(20);
    apb(1'b1, ADDR_IRQ_CLEAR, $random(seed));
    wt(1);
    chk({31'h0, timer_irq}, 0, 0);
    $display("done narrow");
    apb(1'b1, ADDR_LOAD, 32'h1234);
    apb(1'b1, ADDR_CONTROL, 32'h90);
    wt(300);
    rdw(ADDR_COUNT_LOW);
    chk(rd, 292, 302);
    rdw(ADDR_COUNT_HIGH);
    chk(rd, 0, 0);
    chk({31'h0, timer_irq}, 0, 0);
    apb(1'b1, ADDR_CONTROL, 0);
    wt(12);
    $display("done wide");
    apb(1'b1, ADDR_LOAD, 32'hFF00);
    apb(1'b1, ADDR_CONTROL, 32'h25180);
    wt(50);
    apb(1'b1, ADDR_IRQ_CLEAR, 0);
    event_sources <= 18'($random(seed)) & 18'h3FFDF;
    wt(48);
    event_sources[5] <= 1'b1;
    wt(4);
    rdw(ADDR_CAPTURE);
    chk(rd, 32'hFF5A, 32'hFF6A);
    wirq;
    chk({31'h0, timer_irq}, 1, 1);
    rdw(ADDR_COUNT_LOW);
    chk(rd, 0, 8);
    $display("done capture");
    end_sim;
  end
endmodule
`default_nettype wire
